// *** dv/acs_partner.sv ***
/*
 Far side model: analog front end and the three trigger sources.
 Assumes the bench asks for events on the fire inputs.
*/
`timescale 1ns/1ns
`default_nettype none

module acs_partner
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] analogChannel,
   input wire logic [5:0] seed,
   input wire logic [2:0] genFire,
   input wire logic byteFire,
   input wire logic pinFire,
   output logic [9:0] analogData,
   output logic [2:0] generalTimerChannelAFlag,
   output logic byteTimerCompareAFlag,
   output logic externalTriggerPin
);
   // Sample carries the channel number, so a misrouted slot shows
   assign analogData = {analogChannel, seed};

   // Flags set by timer events; pin idles high and is pulled low to trigger
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         generalTimerChannelAFlag <= 3'h0;
         byteTimerCompareAFlag <= 1'b0;
         externalTriggerPin <= 1'b1;
      end
      else
      begin
         generalTimerChannelAFlag <= genFire;
         byteTimerCompareAFlag <= byteFire;
         externalTriggerPin <= !pinFire;
      end
   end
endmodule

`default_nettype wire

// *** dv/acs_sequencer_assertions.sv ***
/*
 Checker of the sequencer ports: bus answer, lengths, scan order, stop, irq.
 Assumes ce held high and control writes with all byte lanes set.
*/
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer_assertions
#(
   parameter int ADDR_BITS = 8,
   parameter int RESULT_BITS = 10,
   parameter int CHANNELS = 6
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_BITS-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq,
   input wire logic [3:0] analogChannel,
   input wire logic converterBusy
);
   localparam int LEN[4] = '{530, 266, 134, 68};
   logic [1:0] timeCode;
   logic scanMode, irqEn, wrAck, stopAck;
   logic [9:0] busyLen;

   // Write strobes as the slave takes them, at the ack edge
   assign wrAck = wb_ack_o && wb_we_i && wb_sel_i[0];
   assign stopAck = wrAck && wb_adr_i[7:2] == 6'h01 && wb_dat_i[1];

   // Shadow of settings, since the checker sees only the pins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         timeCode <= 2'h0;
         scanMode <= 1'b0;
         irqEn <= 1'b0;
      end
      else if (wrAck && wb_adr_i[7:2] == 6'h00)
      begin
         timeCode <= wb_dat_i[8:7];
         scanMode <= wb_dat_i[4];
      end
      else if (wrAck && wb_adr_i[7:2] == 6'h05)
         irqEn <= wb_dat_i[0];
   end

   // Busy run length; wraps in long scans, so only single mode is judged
   always_ff @(posedge clk)
   begin
      if (reset || !converterBusy)
         busyLen <= 10'h000;
      else
         busyLen <= busyLen + 10'h001;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence busReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   endsequence
   sequence ackPulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   ack_one_wait_a: assert property (busReq |=> ackPulse) else $error("bus answer not one cycle after request");
   ack_needs_req_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   result_upper_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20 |-> wb_dat_o[31:RESULT_BITS] == '0)
      else $error("result upper bits not zero");
   scan_order_a: assert property (converterBusy && $past(converterBusy) && analogChannel != $past(analogChannel)
      |-> analogChannel == $past(analogChannel) + 4'h1 || analogChannel == 4'h0) else $error("scan order broken");
   single_length_a: assert property ($fell(converterBusy) && !scanMode && !$past(stopAck) && !$past(reset)
      |-> $past(busyLen) == LEN[timeCode] - 1) else $error("single conversion length wrong");
   scan_runs_a: assert property ($fell(converterBusy) && scanMode && !$past(reset) |-> $past(stopAck))
      else $error("scan ended without stop");
   stop_halts_a: assert property (stopAck |=> !converterBusy) else $error("stop did not halt");
   irq_masked_a: assert property (!irqEn |-> !irq) else $error("irq while disabled");
endmodule

bind acs_sequencer acs_sequencer_assertions #(.ADDR_BITS(ADDR_BITS), .RESULT_BITS(RESULT_BITS), .CHANNELS(CHANNELS))
   chk (.*);

`default_nettype wire

// *** dv/acs_sequencer_tb_top.sv ***
/*
 Testbench of the conversion sequencer, one task per scenario.
 Assumes acs_partner drives analog data and triggers.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acs_regs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module acs_sequencer_tb_top;
   localparam int LEN[4] = '{530, 266, 134, 68};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd, want;
   logic wb_ack_o, irq, converterBusy, byteTimerCompareAFlag, externalTriggerPin;
   logic [9:0] analogData;
   logic [3:0] analogChannel;
   logic [2:0] generalTimerChannelAFlag, generalTimerConvertTriggerEnable = 3'h0, genFire = 3'h0;
   logic byteTimerConvertTriggerEnable = 1'b0, byteFire = 1'b0, pinFire = 1'b0;
   logic [5:0] seed = 6'h00;
   int errors = 0, compares = 0, cycles = 0;

   assign wb_stb_i = wb_cyc_i;
   acs_sequencer dut (.*);
   acs_partner model (.*);

   // Clock and hang guard
   initial
   begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         errors++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One classic cycle; ack and read data are taken at the rising edge where ack is high
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      // A missing answer counts as a mismatch
      if (wb_ack_o !== 1'b1)
         errors++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   // Counts busy cycles until idle
   task automatic waitIdle(output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         if (converterBusy === 1'b1)
            n++;
      end
      while (converterBusy === 1'b1 && n < 700);
   endtask

   task automatic resetTest;
      logic [7:0] adrs[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h34, 8'h38};
      wbx(1'b1, 8'h38, 32'hffffffff);
      for (int i = 0; i < 9; i++)
      begin
         wbx(1'b0, adrs[i], 32'h0);
         `CHK("reset read", 32'h0, rd)
      end
      `CHK("idle busy", 1'b0, converterBusy)
   endtask

   task automatic single(input logic [3:0] ch, input logic [1:0] code);
      int n;
      seed <= seed + 6'h01;
      wbx(1'b1, `ACS_CTRL_OFS, {23'h0, code, 3'h0, ch});
      wbx(1'b1, `ACS_CMD_OFS, 32'h1);
      waitIdle(n);
      `CHK("length", LEN[code], n)
      `CHK("irq masked", 1'b0, irq)
      wbx(1'b0, `ACS_STATUS_OFS, 32'h0);
      want = {29'h0, code != 2'h0, 2'b01};
      `CHK("status", want, rd)
      wbx(1'b0, `ACS_CTRL_OFS, 32'h0);
      want = {23'h0, code, 3'h0, ch};
      `CHK("control", want, rd)
      wbx(1'b0, 8'h20 + 8'(4 * (ch < 4 ? ch : ch - 10)), 32'h0);
      want = {22'h0, ch, seed};
      `CHK("result", want, rd)
      wbx(1'b1, `ACS_CMD_OFS, 32'h2);
      wbx(1'b0, `ACS_STATUS_OFS, 32'h0);
      `CHK("end cleared", 1'b0, rd[0])
   endtask

   task automatic irqTest;
      wbx(1'b0, `ACS_IRQ_STATUS_OFS, 32'h0);
      `CHK("irq sticky", 1'b1, rd[0])
      wbx(1'b1, `ACS_IRQ_ENABLE_OFS, 32'h1);
      @(negedge clk);
      `CHK("irq on", 1'b1, irq)
      wbx(1'b1, `ACS_IRQ_CLEAR_OFS, 32'h1);
      @(negedge clk);
      `CHK("irq off", 1'b0, irq)
   endtask

   task automatic scanTest(input logic [1:0] c);
      logic [3:0] w;
      int n;
      wbx(1'b1, `ACS_CTRL_OFS, {23'h0, 2'h3, 3'h1, 2'h0, c});
      wbx(1'b1, `ACS_CMD_OFS, 32'h1);
      w = 4'h0;
      for (int k = 0; k < 2 * c + 3; k++)
      begin
         for (n = 0; analogChannel !== w && n < 100; n++)
            @(negedge clk);
         `CHK("scan channel", w, analogChannel)
         w = (w == {2'h0, c}) ? 4'h0 : w + 4'h1;
      end
      for (n = 0; irq !== 1'b1 && n < 200; n++)
         @(negedge clk);
      `CHK("pass irq", 1'b1, irq)
      `CHK("still busy", 1'b1, converterBusy)
      for (int i = 0; i <= c; i++)
      begin
         wbx(1'b0, 8'h20 + 8'(4 * i), 32'h0);
         want = {22'h0, 4'(i), seed};
         `CHK("scan result", want, rd)
      end
      wbx(1'b1, `ACS_CMD_OFS, 32'h2);
      @(negedge clk);
      `CHK("stopped", 1'b0, converterBusy)
      wbx(1'b0, `ACS_STATUS_OFS, 32'h0);
      `CHK("stop status", 2'b00, rd[1:0])
      wbx(1'b1, `ACS_IRQ_CLEAR_OFS, 32'h1);
   endtask

   // Fire bits: 0 general timer channel 1, 1 byte timer, 2 pin
   task automatic trig(input logic [1:0] src, input logic [2:0] fire, input logic en, input logic exp);
      int n;
      wbx(1'b1, `ACS_CTRL_OFS, {23'h0, 2'h3, src, 5'h00});
      generalTimerConvertTriggerEnable <= {3{en}};
      byteTimerConvertTriggerEnable <= en;
      @(posedge clk);
      genFire <= {1'b0, fire[0], 1'b0};
      byteFire <= fire[1];
      pinFire <= fire[2];
      repeat (3) @(posedge clk);
      genFire <= 3'h0;
      byteFire <= 1'b0;
      pinFire <= 1'b0;
      waitIdle(n);
      `CHK("trigger start", exp, n > 0)
   endtask

   // Main sequence
   initial
   begin
      static logic [3:0] chs[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'he, 4'hf};
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      resetTest();
      for (int i = 0; i < 6; i++)
         single(chs[i], 2'(i));
      irqTest();
      for (int c = 0; c < 4; c++)
         scanTest(2'(c));
      trig(2'h0, 3'b111, 1'b1, 1'b0);
      trig(2'h1, 3'b001, 1'b0, 1'b0);
      trig(2'h1, 3'b001, 1'b1, 1'b1);
      trig(2'h2, 3'b101, 1'b1, 1'b0);
      trig(2'h2, 3'b010, 1'b0, 1'b0);
      trig(2'h2, 3'b010, 1'b1, 1'b1);
      trig(2'h1, 3'b100, 1'b1, 1'b0);
      trig(2'h3, 3'b100, 1'b0, 1'b1);
      end_sim();
   end
endmodule

`default_nettype wire

// *** hw/acs_pkg.sv ***
/*
 Types shared by the conversion sequencer files.
 Assumes acs_regs.svh supplies the numbers.
*/
package acs_pkg;

   // Sequencer states, Gray coded
   typedef enum logic [1:0]
   {
      ACS_IDLE = 2'b00,
      ACS_CONVERT = 2'b01
   } acs_state_type;

   typedef logic [9:0] acs_count_type;

endpackage

// *** hw/acs_regs.svh ***
/*
 Register offsets, field positions, reset values and cycle counts of the
 conversion sequencer. Assumes a 32-bit Wishbone slave with byte addresses.
*/
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// Byte offsets
`define ACS_CTRL_OFS 8'h00
`define ACS_CMD_OFS 8'h04
`define ACS_STATUS_OFS 8'h08
`define ACS_IRQ_STATUS_OFS 8'h0c
`define ACS_IRQ_CLEAR_OFS 8'h10
`define ACS_IRQ_ENABLE_OFS 8'h14
`define ACS_RESULT_BASE_OFS 8'h20

// Control register fields
`define ACS_CTRL_CHAN_LSB 0
`define ACS_CTRL_SCAN_BIT 4
`define ACS_CTRL_SRC_LSB 5
`define ACS_CTRL_TIME_LSB 7
`define ACS_CTRL_RESET 9'h000

// Command register fields
`define ACS_CMD_START_BIT 0
`define ACS_CMD_STOP_BIT 1

// Status register fields
`define ACS_STAT_END_BIT 0
`define ACS_STAT_BUSY_BIT 1
`define ACS_STAT_SHORT_BIT 2

// Interrupt register fields
`define ACS_IRQ_END_BIT 0
`define ACS_IRQ_ENABLE_RESET 1'b0

// Start source codes
`define ACS_SRC_SOFTWARE 2'h0
`define ACS_SRC_GEN_TIMER 2'h1
`define ACS_SRC_BYTE_TIMER 2'h2
`define ACS_SRC_EXT_PIN 2'h3

// Conversion lengths in clock cycles per time code
`define ACS_CONV_CYCLES_0 10'd530
`define ACS_CONV_CYCLES_1 10'd266
`define ACS_CONV_CYCLES_2 10'd134
`define ACS_CONV_CYCLES_3 10'd68

// Shortest conversion time allowed, and the clock it is judged against
`define ACS_MIN_CONV_NS 8400
`define ACS_CLK_PERIOD_NS 20
`define ACS_MIN_CONV_CYCLES ((`ACS_MIN_CONV_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

// *** hw/acs_result_ram.sv ***
/*
 Small result store, one word per channel, registered read data.
 Assumes a single clock, synchronous reset and a clock enable.
*/
`timescale 1ns/1ns
`default_nettype none

module acs_result_ram
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 6,
   parameter int ABITS = 3
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic writeEn,
   input wire logic [ABITS-1:0] writeAddr,
   input wire logic [WIDTH-1:0] writeData,
   input wire logic [ABITS-1:0] readAddr,
   output logic [WIDTH-1:0] readData
);
   import acs_pkg::*;

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [WIDTH-1:0] rdata;
   } acs_ram_state_type;

   acs_ram_state_type r;
   acs_ram_state_type next_r;

   // Refuse an address width that cannot reach every word
   if ((1 << ABITS) < DEPTH)
   begin : g_check
      $error("acs_result_ram: ABITS too small for DEPTH");
   end

   // Write and registered read; out-of-range reads return zero
   always_comb
   begin
      next_r = r;
      if (writeEn && (int'(writeAddr) < DEPTH))
      begin
         next_r.words[writeAddr] = writeData;
      end
      if (int'(readAddr) < DEPTH)
      begin
         next_r.rdata = r.words[readAddr];
      end
      else
      begin
         next_r.rdata = '0;
      end
   end

   // Results read as zero until a conversion writes them
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         r <= '0;
      end
      else if (ce)
      begin
         r <= next_r;
      end
   end

   assign readData = r.rdata;
endmodule

`default_nettype wire

// *** hw/acs_sequencer.sv ***
/*
 Control logic of a 10-bit successive-approximation converter: Wishbone
 register file, start-source selection, single and scan sequencing,
 conversion timing, result store and end-of-conversion interrupt.
 Assumes the analog front end presents the result of the channel on
 analogChannel at analogData by the last cycle of each conversion, and that
 all trigger inputs are synchronous to clk.
*/
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "acs_regs.svh"

module acs_sequencer
#(
   parameter int ADDR_BITS = 8,
   parameter int RESULT_BITS = 10,
   parameter int CHANNELS = 6
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_BITS-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   input wire logic [2:0] generalTimerChannelAFlag,
   input wire logic [2:0] generalTimerConvertTriggerEnable,
   input wire logic byteTimerCompareAFlag,
   input wire logic byteTimerConvertTriggerEnable,
   input wire logic externalTriggerPin,
   input wire logic [RESULT_BITS-1:0] analogData,
   output logic [3:0] analogChannel,
   output logic converterBusy
);
   import acs_pkg::*;

   // Refuse shapes the register map cannot carry
   if (RESULT_BITS > 16 || CHANNELS != 6 || ADDR_BITS < 6 || ADDR_BITS > 32)
   begin : g_check
      $error("acs_sequencer: unsupported parameter values");
   end

   typedef struct packed
   {
      acs_state_type state;
      logic [3:0] chanSel;
      logic scanMode;
      logic [1:0] startSrc;
      logic [1:0] timeCode;
      logic endFlag;
      acs_count_type count;
      logic [3:0] convChannel;
      logic [2:0] genFlagPrev;
      logic byteFlagPrev;
      logic extPinPrev;
      logic irqStatus;
      logic irqEnable;
      logic ack;
      logic readMem;
      logic [31:0] datOut;
   } acs_core_type;

   acs_core_type r;
   acs_core_type next_r;

   logic busWrite;
   logic busRequest;
   logic startCmd;
   logic stopCmd;
   logic genEvent;
   logic byteEvent;
   logic extEvent;
   logic hwStart;
   logic configValid;
   logic lastCycle;
   logic lastInGroup;
   logic memWrite;
   logic [2:0] memWriteAddr;
   logic [2:0] memReadAddr;
   logic [RESULT_BITS-1:0] memReadData;
   logic [ADDR_BITS-1:0] resultOffset;
   logic isResult;

   // Conversion length for a time code
   function automatic acs_count_type convCycles(input logic [1:0] code);
      case (code)
         2'h0: convCycles = `ACS_CONV_CYCLES_0;
         2'h1: convCycles = `ACS_CONV_CYCLES_1;
         2'h2: convCycles = `ACS_CONV_CYCLES_2;
         2'h3: convCycles = `ACS_CONV_CYCLES_3;
         default: convCycles = `ACS_CONV_CYCLES_0;
      endcase
   endfunction

   // Channel number to result slot; 7 marks a channel that does not exist
   function automatic logic [2:0] chanSlot(input logic [3:0] chan);
      case (chan)
         4'h0: chanSlot = 3'h0;
         4'h1: chanSlot = 3'h1;
         4'h2: chanSlot = 3'h2;
         4'h3: chanSlot = 3'h3;
         4'he: chanSlot = 3'h4;
         4'hf: chanSlot = 3'h5;
         default: chanSlot = 3'h7;
      endcase
   endfunction

   // Match a bus address against a register offset
   function automatic logic atOffset(input logic [ADDR_BITS-1:0] adr, input logic [7:0] ofs);
      atOffset = (adr[ADDR_BITS-1:2] == ADDR_BITS'(ofs) >> 2);
   endfunction

   // Bus decode; a write acts at the edge where ack is already high
   assign busRequest = wb_cyc_i && wb_stb_i;
   assign busWrite = busRequest && wb_we_i && r.ack;
   assign startCmd = busWrite && wb_sel_i[0] && atOffset(wb_adr_i, `ACS_CMD_OFS)
                     && wb_dat_i[`ACS_CMD_START_BIT];
   assign stopCmd = busWrite && wb_sel_i[0] && atOffset(wb_adr_i, `ACS_CMD_OFS)
                    && wb_dat_i[`ACS_CMD_STOP_BIT];

   // Result window: six words from the result base
   assign resultOffset = wb_adr_i - ADDR_BITS'(`ACS_RESULT_BASE_OFS);
   assign isResult = (wb_adr_i >= ADDR_BITS'(`ACS_RESULT_BASE_OFS))
                     && (resultOffset[ADDR_BITS-1:2] < (ADDR_BITS-2)'(CHANNELS));
   assign memReadAddr = isResult ? resultOffset[4:2] : 3'h7;

   // Trigger events are rising flags or the falling pin, seen once per edge
   assign genEvent = |(generalTimerChannelAFlag & ~r.genFlagPrev & generalTimerConvertTriggerEnable);
   assign byteEvent = byteTimerCompareAFlag && !r.byteFlagPrev && byteTimerConvertTriggerEnable;
   assign extEvent = r.extPinPrev && !externalTriggerPin;
   always_comb
   begin
      case (r.startSrc)
         `ACS_SRC_GEN_TIMER: hwStart = genEvent;
         `ACS_SRC_BYTE_TIMER: hwStart = byteEvent;
         `ACS_SRC_EXT_PIN: hwStart = extEvent;
         default: hwStart = 1'b0;
      endcase
   end

   // A start is refused when the channel code names no real channel
   assign configValid = r.scanMode ? (r.chanSel <= 4'h3) : (chanSlot(r.chanSel) != 3'h7);

   // End of one channel's conversion and of one pass through the group
   assign lastCycle = (r.state == ACS_CONVERT) && (r.count == '0);
   assign lastInGroup = !r.scanMode || (r.convChannel[1:0] == r.chanSel[1:0]);
   assign memWrite = lastCycle && !stopCmd && ce;
   assign memWriteAddr = chanSlot(r.convChannel);

   // Sequencer, triggers, registers and interrupt
   always_comb
   begin
      next_r = r;
      next_r.genFlagPrev = generalTimerChannelAFlag;
      next_r.byteFlagPrev = byteTimerCompareAFlag;
      next_r.extPinPrev = externalTriggerPin;

      // Configuration writes, byte lane by byte lane
      if (busWrite && atOffset(wb_adr_i, `ACS_CTRL_OFS))
      begin
         if (wb_sel_i[0])
         begin
            next_r.chanSel = wb_dat_i[`ACS_CTRL_CHAN_LSB +: 4];
            next_r.scanMode = wb_dat_i[`ACS_CTRL_SCAN_BIT];
            next_r.startSrc = wb_dat_i[`ACS_CTRL_SRC_LSB +: 2];
            next_r.timeCode[0] = wb_dat_i[`ACS_CTRL_TIME_LSB];
         end
         if (wb_sel_i[1])
         begin
            next_r.timeCode[1] = wb_dat_i[`ACS_CTRL_TIME_LSB + 1];
         end
      end
      if (busWrite && wb_sel_i[0] && atOffset(wb_adr_i, `ACS_IRQ_ENABLE_OFS))
      begin
         next_r.irqEnable = wb_dat_i[`ACS_IRQ_END_BIT];
      end
      if (busWrite && wb_sel_i[0] && atOffset(wb_adr_i, `ACS_IRQ_CLEAR_OFS)
          && wb_dat_i[`ACS_IRQ_END_BIT])
      begin
         next_r.irqStatus = 1'b0;
      end

      case (r.state)
         ACS_IDLE:
         begin
            // Hardware sources start only from idle; a busy start is ignored
            if (configValid && ((startCmd && r.startSrc == `ACS_SRC_SOFTWARE) || hwStart))
            begin
               next_r.state = ACS_CONVERT;
               next_r.endFlag = 1'b0;
               next_r.count = convCycles(r.timeCode) - 10'd1;
               next_r.convChannel = r.scanMode ? 4'h0 : r.chanSel;
            end
         end
         ACS_CONVERT:
         begin
            if (r.count != '0)
            begin
               next_r.count = r.count - 10'd1;
            end
            else if (lastInGroup)
            begin
               // Result stored at this same edge, so flag and data agree
               next_r.endFlag = 1'b1;
               next_r.irqStatus = 1'b1;
               if (r.scanMode)
               begin
                  next_r.convChannel = 4'h0;
                  next_r.count = convCycles(r.timeCode) - 10'd1;
               end
               else
               begin
                  next_r.state = ACS_IDLE;
               end
            end
            else
            begin
               next_r.convChannel = r.convChannel + 4'h1;
               next_r.count = convCycles(r.timeCode) - 10'd1;
            end
         end
         default:
         begin
            next_r.state = ACS_IDLE;
         end
      endcase

      // Stop overrides the state, end flag and count the sequencer set in this cycle; a new irq status stays set
      if (stopCmd)
      begin
         next_r.state = ACS_IDLE;
         next_r.endFlag = 1'b0;
         next_r.count = '0;
      end

      // Registered ack: one wait cycle, then drop after one cycle of ack
      next_r.ack = busRequest && !r.ack;
      next_r.readMem = busRequest && !r.ack && isResult;
      next_r.datOut = 32'h0000_0000;
      if (busRequest && !r.ack && !wb_we_i)
      begin
         if (atOffset(wb_adr_i, `ACS_CTRL_OFS))
         begin
            next_r.datOut[`ACS_CTRL_CHAN_LSB +: 4] = r.chanSel;
            next_r.datOut[`ACS_CTRL_SCAN_BIT] = r.scanMode;
            next_r.datOut[`ACS_CTRL_SRC_LSB +: 2] = r.startSrc;
            next_r.datOut[`ACS_CTRL_TIME_LSB +: 2] = r.timeCode;
         end
         else if (atOffset(wb_adr_i, `ACS_STATUS_OFS))
         begin
            next_r.datOut[`ACS_STAT_END_BIT] = r.endFlag;
            next_r.datOut[`ACS_STAT_BUSY_BIT] = (r.state == ACS_CONVERT);
            // Warns software that the chosen length is below the analog minimum
            next_r.datOut[`ACS_STAT_SHORT_BIT] = convCycles(r.timeCode) < 10'(`ACS_MIN_CONV_CYCLES);
         end
         else if (atOffset(wb_adr_i, `ACS_IRQ_STATUS_OFS))
         begin
            next_r.datOut[`ACS_IRQ_END_BIT] = r.irqStatus;
         end
         else if (atOffset(wb_adr_i, `ACS_IRQ_ENABLE_OFS))
         begin
            next_r.datOut[`ACS_IRQ_END_BIT] = r.irqEnable;
         end
      end
   end

   // All state of the sequencer; ce low freezes it, bus included
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         r <= '0;
         r.state <= ACS_IDLE;
         r.chanSel <= 4'(`ACS_CTRL_RESET >> `ACS_CTRL_CHAN_LSB);
         r.irqEnable <= `ACS_IRQ_ENABLE_RESET;
         r.extPinPrev <= 1'b1; // Idle-high pin gives no false edge after reset
         r.genFlagPrev <= 3'h7; // Flags already set at reset are not new events
         r.byteFlagPrev <= 1'b1;
      end
      else if (ce)
      begin
         r <= next_r;
      end
   end

   // Per-channel results
   acs_result_ram
   #(
      .WIDTH(RESULT_BITS),
      .DEPTH(CHANNELS),
      .ABITS(3)
   )
   u_results
   (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .writeEn(memWrite),
      .writeAddr(memWriteAddr),
      .writeData(analogData),
      .readAddr(memReadAddr),
      .readData(memReadData)
   );

   // Results are zero-extended, so the upper bits of the 32-bit word read zero
   assign wb_dat_o = r.readMem ? {{(32 - RESULT_BITS){1'b0}}, memReadData} : r.datOut;
   assign wb_ack_o = r.ack;
   assign irq = r.irqStatus && r.irqEnable;
   assign analogChannel = r.convChannel;
   assign converterBusy = (r.state == ACS_CONVERT);
endmodule

`default_nettype wire
